/* File: src/plb_char_rx.sv */
// Nine-bit character receiver with pin synchroniser for the shared bus.
`timescale 1ns/1ps
module plb_char_rx
   import plb_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       line_in,
   output logic            char_valid,
   output logic [8:0]      char_data
);

   // All receiver state in one record.
   typedef struct packed {
      logic                 sync1;    // First synchroniser stage.
      logic                 sync2;    // Second synchroniser stage.
      plb_rx_state_t        state;    // Receiver state.
      logic [BIT_CNT_W-1:0] cnt;      // Bit timer.
      logic [3:0]           idx;      // Data bit index.
      logic [8:0]           shreg;    // Data being assembled.
      logic                 valid;    // One-cycle character strobe.
      logic [8:0]           data;     // Last good character.
   } plb_rx_t;

   plb_rx_t r_q;   // Registered state.
   plb_rx_t r_d;   // Next state.

   // Frame decoding: find the start edge, sample each bit in its middle.
   always_comb begin
      r_d       = r_q;
      r_d.sync1 = line_in;
      r_d.sync2 = r_q.sync1;
      r_d.valid = 1'b0;
      case (r_q.state)
         RX_IDLE: begin
            // A low line marks a possible start bit.
            if (!r_q.sync2) begin
               r_d.state = RX_START;
               r_d.cnt   = BIT_CNT_W'(HALF_BIT_CYC - 1);
            end
         end
         RX_START: begin
            if (r_q.cnt != BIT_CNT_RST) begin
               r_d.cnt = r_q.cnt - 1'b1;
            end else if (r_q.sync2) begin
               // A glitch, not a start bit.
               r_d.state = RX_IDLE;
            end else begin
               r_d.state = RX_DATA;
               r_d.cnt   = BIT_CNT_W'(BIT_CYC - 1);
               r_d.idx   = 4'h0;
            end
         end
         RX_DATA: begin
            if (r_q.cnt != BIT_CNT_RST) begin
               r_d.cnt = r_q.cnt - 1'b1;
            end else begin
               // Least significant bit arrives first.
               r_d.shreg = {r_q.sync2, r_q.shreg[8:1]};
               r_d.cnt   = BIT_CNT_W'(BIT_CYC - 1);
               if (r_q.idx == 4'(DATA_BITS - 1)) begin
                  r_d.state = RX_STOP;
               end else begin
                  r_d.idx = r_q.idx + 1'b1;
               end
            end
         end
         default: begin
            if (r_q.cnt != BIT_CNT_RST) begin
               r_d.cnt = r_q.cnt - 1'b1;
            end else begin
               // Only a character with a good stop bit is passed on.
               r_d.state = RX_IDLE;
               if (r_q.sync2) begin
                  r_d.valid = 1'b1;
                  r_d.data  = r_q.shreg;
               end
            end
         end
      endcase
   end

   // State register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_q <= '{sync1: 1'b1, sync2: 1'b1, state: RX_IDLE, cnt: BIT_CNT_RST,
                  idx: 4'h0, shreg: 9'h000, valid: 1'b0, data: 9'h000};
      end else begin
         r_q <= r_d;
      end
   end

   assign char_valid = r_q.valid;
   assign char_data  = r_q.data;

endmodule : plb_char_rx

/* File: src/plb_panel_node.sv */
// Control panel node for the polled half-duplex lamp bus.
//
// Contract
// - Transmit and receive at 38.4K baud.
// - Frame: start, nine data LSB first, stop.
// - Ninth bit high marks an address.
// - Panels 0-15; lamps 16 to 56.
// - Transmit only after own address received.
// - Lamp-select value precedes the commands.
// - Pan rate 01 plus speed byte.
// - Tilt rate 02 plus speed byte.
// - Toggle 0A sent once per press.
// - Focus 0B repeated while button held.
// - Check byte is sum, select bit 7 clear.
`timescale 1ns/1ps
module plb_panel_node
   import plb_pkg::*;
(
   input  wire logic       CORE_CLK,
   input  wire logic       RESET,
   input  wire logic       BUS_I,
   output logic            BUS_O,
   output logic            BUS_OE,
   input  wire logic [3:0] PANEL_SW,
   input  wire logic [4:0] LAMP_SW,
   input  wire logic       PAN_ACTIVE,
   input  wire logic [7:0] PAN_RATE,
   input  wire logic       TILT_ACTIVE,
   input  wire logic [7:0] TILT_RATE,
   input  wire logic       LAMP_PRESS,
   input  wire logic       FOCUS_HELD,
   output logic            TX_BUSY,
   output logic            RX_VALID,
   output logic [8:0]      RX_DATA
);

   // All node state in one record.
   typedef struct packed {
      logic [3:0]           psw1;     // Panel switch first stage.
      logic [3:0]           psw2;     // Panel switch second stage.
      logic [4:0]           lsw1;     // Lamp switch first stage.
      logic [4:0]           lsw2;     // Lamp switch second stage.
      plb_tx_state_t        state;    // Transmitter state.
      logic [BIT_CNT_W-1:0] cnt;      // Bit timer.
      logic [3:0]           bit_idx;  // Bit within current frame.
      logic [3:0]           item;     // Character being sent.
      logic [3:0]           count;    // Characters in this slot.
      logic [10:0]          frame;    // Frame being shifted out.
      logic [SLOT_CHARS-1:0][8:0] chars; // Characters of this slot.
      logic                 tgl_pend; // Lamp toggle awaiting a slot.
      logic                 bus_o;    // Line level driven.
      logic                 bus_oe;   // Line driver enable.
      logic                 busy;     // Slot transmission in progress.
   } plb_node_t;

   plb_node_t n_q;   // Registered state.
   plb_node_t n_d;   // Next state.

   logic       rx_valid;   // Character strobe from the receiver.
   logic [8:0] rx_data;    // Received character.

   // Clamp a speed byte into the legal window around the centre.
   function automatic logic [7:0] clamp_speed(input logic [7:0] v);
      logic [7:0] r;
      r = v;
      if (v > SPEED_MAX) begin
         r = SPEED_MAX;
      end else if (v < SPEED_MIN) begin
         r = SPEED_MIN;
      end
      return r;
   endfunction : clamp_speed

   // Receiver for everything seen on the shared line.
   plb_char_rx u_rx (
      .clk        (CORE_CLK),
      .rst        (RESET),
      .line_in    (BUS_I),
      .char_valid (rx_valid),
      .char_data  (rx_data)
   );

   // Slot detection, list building and serial transmission.
   always_comb begin
      logic [7:0] sel;   // Lamp-select value.
      logic [7:0] sum;   // Running check byte.
      logic [3:0] n;     // Characters placed so far.
      logic       act;   // Any activity to report.
      logic       mine;  // Own panel address seen.
      sel  = 8'h00;
      sum  = 8'h00;
      n    = 4'h0;
      act  = 1'b0;
      mine = 1'b0;
      n_d  = n_q;
      n_d.psw1 = PANEL_SW;
      n_d.psw2 = n_q.psw1;
      n_d.lsw1 = LAMP_SW;
      n_d.lsw2 = n_q.lsw1;
      // A press is remembered until its command leaves in a slot.
      if (LAMP_PRESS) begin
         n_d.tgl_pend = 1'b1;
      end
      // Own slot: address mark set and low byte equal to the panel switches.
      mine = rx_valid && rx_data[ADDR_MARK_BIT] && (n_q.state == TX_IDLE) &&
             (rx_data[7:0] == {4'h0, n_q.psw2});
      act  = PAN_ACTIVE || TILT_ACTIVE || n_q.tgl_pend || FOCUS_HELD;
      case (n_q.state)
         TX_IDLE: begin
            n_d.bus_oe = 1'b0;
            n_d.bus_o  = 1'b1;
            n_d.busy   = 1'b0;
            if (mine && act) begin
               // Lamp-select first, bit 7 clear, address mark set.
               sel = {3'h0, n_q.lsw2} & SEL_MASK;
               n_d.chars[0] = {1'b1, sel};
               sum = sel;
               n = 4'h1;
               // Commands follow in ascending code order.
               if (PAN_ACTIVE) begin
                  n_d.chars[n[2:0]] = {1'b0, CMD_PAN_RATE};
                  n_d.chars[n[2:0] + 3'h1] = {1'b0, clamp_speed(PAN_RATE)};
                  sum = sum + CMD_PAN_RATE + clamp_speed(PAN_RATE);
                  n = n + 4'h2;
               end
               if (TILT_ACTIVE) begin
                  n_d.chars[n[2:0]] = {1'b0, CMD_TILT_RATE};
                  n_d.chars[n[2:0] + 3'h1] = {1'b0, clamp_speed(TILT_RATE)};
                  sum = sum + CMD_TILT_RATE + clamp_speed(TILT_RATE);
                  n = n + 4'h2;
               end
               if (n_q.tgl_pend) begin
                  n_d.chars[n[2:0]] = {1'b0, CMD_LAMP_TGL};
                  sum = sum + CMD_LAMP_TGL;
                  n = n + 4'h1;
                  // Consumed here; a press in this same cycle stays pending.
                  n_d.tgl_pend = LAMP_PRESS;
               end
               if (FOCUS_HELD) begin
                  n_d.chars[n[2:0]] = {1'b0, CMD_FOCUS};
                  sum = sum + CMD_FOCUS;
                  n = n + 4'h1;
               end
               // Check byte closes the slot, giving 3 to 8 characters.
               n_d.chars[n[2:0]] = {1'b0, sum};
               n_d.count = n + 4'h1;
               n_d.item  = 4'h0;
               n_d.state = TX_TURN;
               n_d.busy  = 1'b1;
               n_d.cnt   = BIT_CNT_W'(BIT_CYC - 1);
            end
         end
         TX_TURN: begin
            // One bit time of quiet lets the master turn its line round.
            if (n_q.cnt != BIT_CNT_RST) begin
               n_d.cnt = n_q.cnt - 1'b1;
            end else begin
               n_d.state   = TX_SEND;
               n_d.frame   = {1'b1, n_q.chars[0], 1'b0};
               n_d.bit_idx = 4'h0;
               n_d.bus_oe  = 1'b1;
               n_d.bus_o   = 1'b0;
               n_d.cnt     = BIT_CNT_W'(BIT_CYC - 1);
            end
         end
         default: begin
            if (n_q.cnt != BIT_CNT_RST) begin
               n_d.cnt = n_q.cnt - 1'b1;
            end else if (n_q.bit_idx != 4'(FRAME_BITS - 1)) begin
               // Next bit of the frame, least significant first.
               n_d.bit_idx = n_q.bit_idx + 1'b1;
               n_d.bus_o   = n_q.frame[n_q.bit_idx + 4'h1];
               n_d.cnt     = BIT_CNT_W'(BIT_CYC - 1);
            end else if (n_q.item + 4'h1 < n_q.count) begin
               // Next character follows directly, no gap.
               n_d.item    = n_q.item + 1'b1;
               n_d.frame   = {1'b1, n_q.chars[n_q.item[2:0] + 3'h1], 1'b0};
               n_d.bit_idx = 4'h0;
               n_d.bus_o   = 1'b0;
               n_d.cnt     = BIT_CNT_W'(BIT_CYC - 1);
            end else begin
               // Slot finished: release the line.
               n_d.state  = TX_IDLE;
               n_d.bus_oe = 1'b0;
               n_d.bus_o  = 1'b1;
               n_d.busy   = 1'b0;
            end
         end
      endcase
   end

   // State register.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         n_q <= '{psw1: 4'h0, psw2: 4'h0, lsw1: 5'h00, lsw2: 5'h00, state: TX_IDLE,
                  cnt: BIT_CNT_RST, bit_idx: 4'h0, item: 4'h0, count: 4'h0,
                  frame: 11'h7FF, chars: '0, tgl_pend: 1'b0, bus_o: 1'b1,
                  bus_oe: 1'b0, busy: 1'b0};
      end else begin
         n_q <= n_d;
      end
   end

   assign BUS_O    = n_q.bus_o;
   assign BUS_OE   = n_q.bus_oe;
   assign TX_BUSY  = n_q.busy;
   assign RX_VALID = rx_valid;
   assign RX_DATA  = rx_data;

endmodule : plb_panel_node

/* File: src/plb_pkg.sv */
// Shared constants and types for the polled lamp panel bus node.
package plb_pkg;

   // System clock rate in hertz.
   localparam int unsigned CLK_HZ        = 40_000_000;
   // Fixed line rate in baud.
   localparam int unsigned BAUD_RATE     = 38_400;
   // Clock cycles per bit, rounded to the nearest whole cycle.
   localparam int unsigned BIT_CYC       = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
   // Clock cycles to the middle of the start bit.
   localparam int unsigned HALF_BIT_CYC  = BIT_CYC / 2;
   // Width of the bit timer.
   localparam int unsigned BIT_CNT_W     = 11;

   // Bits in one character frame: start, nine data, stop.
   localparam int unsigned FRAME_BITS    = 11;
   // Data bits in one character.
   localparam int unsigned DATA_BITS     = 9;
   // Bit index of the address marker within a character.
   localparam int unsigned ADDR_MARK_BIT = 8;

   // Lowest and highest panel bus address.
   localparam logic [7:0] PANEL_ADDR_MIN = 8'h00;
   localparam logic [7:0] PANEL_ADDR_MAX = 8'h0F;
   // Lowest and highest lamp bus address.
   localparam logic [7:0] LAMP_ADDR_MIN  = 8'h10;
   localparam logic [7:0] LAMP_ADDR_MAX  = 8'h38;

   // Command codes sent by a panel, in ascending order.
   localparam logic [7:0] CMD_PAN_RATE   = 8'h01;
   localparam logic [7:0] CMD_TILT_RATE  = 8'h02;
   localparam logic [7:0] CMD_LAMP_TGL   = 8'h0A;
   localparam logic [7:0] CMD_FOCUS      = 8'h0B;

   // Speed byte centre and the lowest and highest legal speed values.
   localparam logic [7:0] SPEED_CENTRE   = 8'h80;
   localparam logic [7:0] SPEED_MIN      = 8'h40;
   localparam logic [7:0] SPEED_MAX      = 8'hC0;

   // Mask that keeps bit 7 of the lamp-select value clear.
   localparam logic [7:0] SEL_MASK       = 8'h7F;
   // Slots in the outgoing character list.
   localparam int unsigned SLOT_CHARS    = 8;

   // Reset values.
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 11'h000;

   // Transmitter states of the panel node.
   typedef enum logic [1:0] {
      TX_IDLE,
      TX_TURN,
      TX_SEND
   } plb_tx_state_t;

   // Receiver states of the character receiver.
   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_DATA,
      RX_STOP
   } plb_rx_state_t;

endpackage : plb_pkg

/* File: testbench/plb_bus_master.sv */
// Master lamp model that polls addresses and captures what other nodes send.
`timescale 1ns/1ps
module plb_bus_master
   import plb_pkg::*;
#(
   parameter int unsigned DEAD_CYC = 40000
)
(
   input  wire logic clk,
   input  wire logic line,
   output logic      drv_o,
   output logic      drv_en
);
   logic [8:0] rx_q [$];  // Characters heard from other nodes.
   logic       timed_out; // Set when a slot never went quiet.

   // Start released, with the line biased to mark.
   initial begin
      drv_o     = 1'b1;
      drv_en    = 1'b0;
      timed_out = 1'b0;
   end

   // Sends one character: start, nine data bits LSB first, stop.
   task automatic send_char(input logic [8:0] c);
      logic [10:0] f;
      f = {1'b1, c, 1'b0};
      @(posedge clk);
      #1;
      drv_en = 1'b1;
      for (int i = 0; i < FRAME_BITS; i++) begin
         drv_o = f[i];
         repeat (BIT_CYC) @(posedge clk);
         #1;
      end
      drv_o  = 1'b1;
      drv_en = 1'b0;
   endtask : send_char

   // Acts as the default master: sends one address, then waits for a quiet line.
   // The quiet time must stay above the longest run of mark bits in a slot,
   // or the wait ends in the middle of a reply.
   task automatic poll(input logic [7:0] addr);
      int quiet;
      int n;
      send_char({1'b1, addr});
      quiet = 0;
      n     = 0;
      while (quiet < DEAD_CYC && n < 100000) begin
         @(posedge clk);
         quiet = (line === 1'b1) ? quiet + 1 : 0;
         n++;
      end
      if (quiet < DEAD_CYC) timed_out = 1'b1;
   endtask : poll

   // Receives frames from others, sampling each bit at its middle.
   initial forever begin
      logic [8:0] c;
      @(negedge line);
      if (!drv_en) begin
         repeat (HALF_BIT_CYC) @(posedge clk);
         for (int i = 0; i < DATA_BITS; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            c[i] = line;
         end
         repeat (BIT_CYC) @(posedge clk);
         if (line === 1'b1) rx_q.push_back(c);
      end
   end
endmodule : plb_bus_master

/* File: testbench/plb_node_monitor.sv */
// Checker of line timing and slot behaviour at the panel node's ports.
`timescale 1ns/1ps
module plb_node_monitor
   import plb_pkg::*;
(
   input wire logic       CORE_CLK,
   input wire logic       RESET,
   input wire logic       BUS_O,
   input wire logic       BUS_OE,
   input wire logic [3:0] PANEL_SW,
   input wire logic       PAN_ACTIVE,
   input wire logic       TILT_ACTIVE,
   input wire logic       FOCUS_HELD,
   input wire logic       TX_BUSY,
   input wire logic       RX_VALID,
   input wire logic [8:0] RX_DATA
);
   // Cycles taken by one whole character on the line.
   localparam int unsigned FRAME_CYC = FRAME_BITS * BIT_CYC;
   int unsigned turn_q;  // Slot cycles spent before the driver turns on.
   int unsigned hold_q;  // Cycles since the driven level last changed.
   int unsigned oe_q;    // Cycles the driver has been on.
   logic        bus_o_q; // Driven level one cycle back.

   // Helper counters that measure turnaround, bit width and slot length.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         turn_q  <= 0;
         hold_q  <= 0;
         oe_q    <= 0;
         bus_o_q <= 1'b1;
      end else begin
         turn_q  <= (TX_BUSY && !BUS_OE) ? turn_q + 1 : 0;
         hold_q  <= (BUS_O != bus_o_q) ? 1 : hold_q + 1;
         oe_q    <= BUS_OE ? oe_q + 1 : 0;
         bus_o_q <= BUS_O;
      end
   end

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);

   // Our own panel address arrives while the node is idle.
   sequence own_slot;
      RX_VALID && RX_DATA == {1'b1, 4'h0, PANEL_SW} && !TX_BUSY;
   endsequence
   // Some joystick or focus activity waits to be reported.
   sequence has_work;
      PAN_ACTIVE || TILT_ACTIVE || FOCUS_HELD;
   endsequence

   a_idle_mark: assert property (!BUS_OE |-> BUS_O)
      else $error("line not at mark while released");
   a_start_low: assert property ($rose(BUS_OE) |-> !BUS_O)
      else $error("slot does not open with a start bit");
   a_bit_width: assert property ((BUS_OE && $past(BUS_OE) && $changed(BUS_O)) |->
      hold_q % BIT_CYC == 0) else $error("bit time on line is wrong");
   a_frame_count: assert property ($fell(BUS_OE) |-> (oe_q % FRAME_CYC == 0 &&
      oe_q >= 2 * FRAME_CYC && oe_q <= 10 * FRAME_CYC)) else $error("bad slot length");
   a_turn_around: assert property ($rose(BUS_OE) |-> turn_q == BIT_CYC)
      else $error("turnaround before reply is wrong");
   a_busy_cause: assert property ($rose(TX_BUSY) |-> $past(RX_VALID) && $past(RX_DATA[8]))
      else $error("slot opened without an address");
   a_slot_taken: assert property (own_slot ##0 has_work |=> TX_BUSY)
      else $error("own slot with work not taken");
   a_drive_in_slot: assert property (BUS_OE |-> TX_BUSY)
      else $error("line driven outside a slot");
   a_busy_release: assert property (($fell(BUS_OE) || $fell(TX_BUSY)) |->
      ($fell(BUS_OE) && $fell(TX_BUSY))) else $error("busy and driver not released together");
   a_rx_single: assert property (RX_VALID |=> !RX_VALID)
      else $error("receive strobe longer than one cycle");
endmodule : plb_node_monitor

bind plb_panel_node plb_node_monitor plb_node_monitor_i (
   .CORE_CLK(CORE_CLK), .RESET(RESET), .BUS_O(BUS_O), .BUS_OE(BUS_OE),
   .PANEL_SW(PANEL_SW), .PAN_ACTIVE(PAN_ACTIVE), .TILT_ACTIVE(TILT_ACTIVE),
   .FOCUS_HELD(FOCUS_HELD), .TX_BUSY(TX_BUSY), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA));

/* File: testbench/test_plb_panel_node.sv */
// Self-checking bench for the panel node against a polling master model.
`timescale 1ns/1ps
module test_plb_panel_node;
   import plb_pkg::*;
   logic       CORE_CLK;        // System clock.
   logic       RESET;           // Asynchronous reset.
   logic       BUS_I;           // Resolved line level.
   logic       BUS_O;           // Level driven by the node.
   logic       BUS_OE;          // Node driver enable.
   logic [3:0] PANEL_SW;        // Panel address switches.
   logic [4:0] LAMP_SW;         // Lamp select switches.
   logic       PAN_ACTIVE;      // Pan joystick deflected.
   logic [7:0] PAN_RATE;        // Pan speed.
   logic       TILT_ACTIVE;     // Tilt joystick deflected.
   logic [7:0] TILT_RATE;       // Tilt speed.
   logic       FOCUS_HELD;      // Focus button held.
   logic       LAMP_PRESS;      // Lamp button pulse.
   logic       TX_BUSY;         // Node owns a slot.
   logic       RX_VALID;        // Character received.
   logic [8:0] RX_DATA;         // Last character.
   logic       m_o;             // Model drive level.
   logic       m_en;            // Model driver enable.
   logic [8:0] last_rx;         // Last character the node reported.
   int         fails;           // Mismatch count.
   int         samples_checked; // Comparison count.

   // Released line rests at mark through its bias network.
   assign BUS_I = BUS_OE ? BUS_O : (m_en ? m_o : 1'b1);

   // Clock generation.
   initial CORE_CLK = 1'b0;
   always #12.5 CORE_CLK = ~CORE_CLK;

   // Keep the last character the node reports.
   always @(posedge CORE_CLK) begin
      if (RX_VALID === 1'b1) last_rx <= RX_DATA;
   end

   plb_panel_node plb_panel_node_i (
      .CORE_CLK(CORE_CLK), .RESET(RESET), .BUS_I(BUS_I), .BUS_O(BUS_O), .BUS_OE(BUS_OE),
      .PANEL_SW(PANEL_SW), .LAMP_SW(LAMP_SW), .PAN_ACTIVE(PAN_ACTIVE), .PAN_RATE(PAN_RATE),
      .TILT_ACTIVE(TILT_ACTIVE), .TILT_RATE(TILT_RATE), .LAMP_PRESS(LAMP_PRESS),
      .FOCUS_HELD(FOCUS_HELD),
      .TX_BUSY(TX_BUSY), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA));

   plb_bus_master #(.DEAD_CYC(4000)) plb_bus_master_i (
      .clk(CORE_CLK), .line(BUS_I), .drv_o(m_o), .drv_en(m_en));

   // Compares one value and reports a difference.
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Prints the verdict and ends the run.
   task automatic conclude;
      if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   // Polls one address; a slot that never goes quiet ends the run.
   task automatic poll_slot(input logic [7:0] addr);
      plb_bus_master_i.rx_q.delete();
      plb_bus_master_i.poll(addr);
      // Look at the node's outputs away from the edge that launches them.
      @(negedge CORE_CLK);
      if (plb_bus_master_i.timed_out) begin
         fails++;
         conclude();
      end
   endtask : poll_slot

   // Own address with nothing to report: the slot stays silent.
   task automatic s_idle_slot;
      poll_slot(8'h05);
      check(last_rx, 9'h105);
      check(9'(TX_BUSY), 9'h000);
      check(9'(plb_bus_master_i.rx_q.size()), 9'h000);
   endtask : s_idle_slot

   // A lamp address sharing our low nibble must not open our slot.
   task automatic s_foreign;
      @(posedge CORE_CLK);
      #1 LAMP_PRESS = 1'b1;
      @(posedge CORE_CLK);
      #1 LAMP_PRESS = 1'b0;
      poll_slot(8'h15);
      check(last_rx, 9'h115);
      check(9'(plb_bus_master_i.rx_q.size()), 9'h000);
   endtask : s_foreign

   // Over-range pan, tilt, focus and the pending toggle, all in one full slot.
   task automatic s_full_slot;
      logic [8:0] exp [8];
      exp = '{9'h106, 9'h001, 9'h0C0, 9'h002, 9'h050, 9'h00A, 9'h00B, 9'h02E};
      @(posedge CORE_CLK);
      #1 PAN_ACTIVE = 1'b1;
      PAN_RATE    = 8'hC5;
      TILT_ACTIVE = 1'b1;
      TILT_RATE   = 8'h50;
      FOCUS_HELD  = 1'b1;
      poll_slot(8'h05);
      check(9'(plb_bus_master_i.rx_q.size()), 9'h008);
      for (int i = 0; i < 8; i++) begin
         check(plb_bus_master_i.rx_q[i], exp[i]);
      end
      check(9'(BUS_OE), 9'h000);
      @(posedge CORE_CLK);
      #1 PAN_ACTIVE = 1'b0;
      TILT_ACTIVE = 1'b0;
      FOCUS_HELD  = 1'b0;
   endtask : s_full_slot

   // Main sequence: reset, then the scenarios in turn.
   initial begin
      fails           = 0;
      samples_checked = 0;
      RESET           = 1'b1;
      PANEL_SW        = 4'b0101;
      LAMP_SW         = 5'b00110;
      PAN_ACTIVE      = 1'b0;
      PAN_RATE        = 8'h80;
      TILT_ACTIVE     = 1'b0;
      TILT_RATE       = 8'h80;
      FOCUS_HELD      = 1'b0;
      LAMP_PRESS      = 1'b0;
      repeat (20) @(posedge CORE_CLK);
      #1 RESET = 1'b0;
      repeat (3) @(posedge CORE_CLK);
      s_idle_slot();
      s_foreign();
      s_full_slot();
      conclude();
   end
endmodule : test_plb_panel_node
